// >>> verilog/otfr_pkg.sv
package otfr_pkg;

    // command codes of the supervision registers
    localparam logic [7:0]  CMD_FAULT_THR   = 8'h4F;
    localparam logic [7:0]  CMD_REACTION    = 8'h50;
    localparam logic [7:0]  CMD_WARN_THR    = 8'h51;

    // fields of the fault reaction byte
    localparam int          DELAY_LSB       = 0;
    localparam int          DELAY_MSB       = 2;
    localparam int          RETRY_LSB       = 3;
    localparam int          RETRY_MSB       = 5;
    localparam int          RESP_LSB        = 6;
    localparam int          RESP_MSB        = 7;
    localparam int          REACT_W         = 8;
    localparam int          LIN_W           = 16;
    localparam int          MANT_MSB        = 10;

    localparam logic [1:0]  RESP_IGNORE     = 2'h0;
    localparam logic [1:0]  RESP_DISABLE    = 2'h2;
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    localparam logic [2:0]  CNT_ZERO        = 3'h0;
    localparam logic [2:0]  CNT_ONE         = 3'h1;

    // reset contents of the registers
    localparam logic [7:0]  REACTION_RST    = 8'h80;
    localparam logic [15:0] FAULT_THR_RST   = 16'h007D;
    localparam logic [15:0] WARN_THR_RST    = 16'h0073;
    localparam logic [15:0] RDATA_ZERO      = 16'h0000;

    // delay unit and clock rate
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          DELAY_UNIT_MS   = 200;
    localparam int          NS_PER_MS       = 1000000;
    localparam int          TICK_CYCLES     = DELAY_UNIT_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int          TICK_W          = 22;
    localparam logic [21:0] TICK_CNT_ZERO   = 22'h000000;

    typedef enum logic [1:0] {
        OTFR_RUN     = 2'h0,
        OTFR_DELAY   = 2'h1,
        OTFR_RESTART = 2'h3,
        OTFR_LATCHED = 2'h2
    } otfr_state_e;

    // with exponent 0 the value is the signed eleven-bit mantissa in degrees
    function automatic logic signed [10:0] otfr_mant(input logic [15:0] v);
        return $signed(v[MANT_MSB:0]);
    endfunction

    function automatic logic otfr_above(input logic [15:0] meas, input logic [15:0] lim);
        return otfr_mant(meas) > otfr_mant(lim);
    endfunction

endpackage

// >>> verilog/otfr_tick_gen.sv
module otfr_tick_gen #(
    parameter int TICK_CYCLES = otfr_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic clr,
    output logic      tick
);

    localparam logic [otfr_pkg::TICK_W-1:0] TOP  = otfr_pkg::TICK_W'(TICK_CYCLES - 1);
    localparam logic [otfr_pkg::TICK_W-1:0] STEP = otfr_pkg::TICK_W'(1);

    logic [otfr_pkg::TICK_W-1:0] cnt_reg;
    logic [otfr_pkg::TICK_W-1:0] cnt_next;
    logic                        wrap;

    // restarted by clr so the first unit of a delay is a full one
    assign wrap     = (cnt_reg == TOP);
    assign cnt_next = (clr || wrap) ? otfr_pkg::TICK_CNT_ZERO : cnt_reg + STEP;

    // R11 unit tick
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= otfr_pkg::TICK_CNT_ZERO;
            tick    <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            tick    <= wrap && !clr;
        end
    end

    // R11 tick period
    chk_tick_period: assert property (@(posedge clk) disable iff (!rstn) // R11
        ce && wrap && !clr |=> tick)
        else $error("unit tick missing after full count");

endmodule // otfr_tick_gen

// >>> verilog/otfr_cmp.sv
module otfr_cmp (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] fault_thr,
    input  wire logic [15:0] warn_thr,
    output logic             fault_lvl,
    output logic             warn_lvl
);

    logic fault_hit;
    logic warn_hit;

    // R10 fault trip
    assign fault_hit = otfr_pkg::otfr_above(temp_meas, fault_thr);
    // R8 R9 warning trip
    assign warn_hit  = otfr_pkg::otfr_above(temp_meas, warn_thr);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_lvl <= 1'b0;
            warn_lvl  <= 1'b0;
        end else if (ce) begin
            fault_lvl <= fault_hit;
            warn_lvl  <= warn_hit;
        end
    end

    // R8 equal is no warning
    chk_warn_equal: assert property (@(posedge clk) disable iff (!rstn) // R8
        ce && (temp_meas[10:0] == warn_thr[10:0]) |=> !warn_lvl)
        else $error("warning raised at the threshold itself");

    // R9 one degree above warns
    chk_warn_above: assert property (@(posedge clk) disable iff (!rstn) // R9
        ce && ($signed(temp_meas[10:0]) == $signed(warn_thr[10:0]) + 11'sh001)
        && (warn_thr[10:0] != 11'h3FF) |=> warn_lvl)
        else $error("warning missing one degree above threshold");

    // R10 equal is no fault
    chk_fault_equal: assert property (@(posedge clk) disable iff (!rstn) // R10
        ce && (temp_meas[10:0] == fault_thr[10:0]) |=> !fault_lvl)
        else $error("fault raised at the threshold itself");

endmodule // otfr_cmp

// >>> verilog/otfr_top.sv
// Contract
// R1 - reaction bits 2:0 are the unsigned restart delay in 200 ms units.
// R2 - response 00 keeps the output running through an over-temperature fault.
// R3 - response 10 disables the output on fault, then follows the retry count.
// R4 - retry count 000 never restarts; output stays off until cleared.
// R5 - retry counts 1 to 6 restart that often, then latch off until cleared.
// R6 - successive restart attempts are spaced by the programmed delay.
// R7 - retry count 111 retries until commanded off, bias lost, or other fault.
// R8 - warning flag rises only when temperature is strictly above its threshold.
// R9 - warning threshold is linear, exponent 0, degrees Celsius.
// R10 - fault threshold is linear, exponent 0; exceeding it triggers the response.
// R11 - restart delay counts 200 ms ticks derived from the system clock.
module otfr_top #(
    parameter int TICK_CYCLES = otfr_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic [15:0] temp_meas,
    input  wire logic        cmd_off,
    input  wire logic        bias_ok,
    input  wire logic        other_fault,
    input  wire logic        fault_clear,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_unknown,
    output logic             out_enable,
    output logic             ot_fault_flag,
    output logic             ot_warn_flag,
    output logic             latched_off
);

    logic [7:0]            reaction_reg;
    logic [15:0]           fault_thr_reg;
    logic [15:0]           warn_thr_reg;
    otfr_pkg::otfr_state_e state_reg;
    otfr_pkg::otfr_state_e state_next;
    logic [2:0]            attempt_reg;
    logic [2:0]            attempt_next;
    logic [2:0]            delay_reg;
    logic [2:0]            delay_next;
    logic                  fault_lvl;
    logic                  warn_lvl;
    logic                  tick;

    wire  [1:0]            resp_f   = reaction_reg[otfr_pkg::RESP_MSB:otfr_pkg::RESP_LSB];
    wire  [2:0]            retry_f  = reaction_reg[otfr_pkg::RETRY_MSB:otfr_pkg::RETRY_LSB];
    wire  [2:0]            delay_f  = reaction_reg[otfr_pkg::DELAY_MSB:otfr_pkg::DELAY_LSB];

    wire                   hit_reaction  = (cmd_code == otfr_pkg::CMD_REACTION);
    wire                   hit_fault_thr = (cmd_code == otfr_pkg::CMD_FAULT_THR);
    wire                   hit_warn_thr  = (cmd_code == otfr_pkg::CMD_WARN_THR);
    wire                   hit_any       = hit_reaction || hit_fault_thr || hit_warn_thr;

    wire   [15:0]          rdata_sel =
        hit_reaction  ? {8'h00, reaction_reg} :
        hit_fault_thr ? fault_thr_reg :
        hit_warn_thr  ? warn_thr_reg  : otfr_pkg::RDATA_ZERO;

    // R7 ends of continuous retry
    wire                   stop_cond   = cmd_off || !bias_ok || other_fault;
    // R3 disable response
    wire                   shut_req    = fault_lvl && (resp_f == otfr_pkg::RESP_DISABLE);
    wire                   forever_f   = (retry_f == otfr_pkg::RETRY_FOREVER);
    // R5 attempts left
    wire                   more_tries  = forever_f || (attempt_reg < retry_f);
    wire                   enter_delay = (state_reg != otfr_pkg::OTFR_DELAY) &&
                                         (state_next == otfr_pkg::OTFR_DELAY);
    wire                   out_next    = ((state_next == otfr_pkg::OTFR_RUN) ||
                                          (state_next == otfr_pkg::OTFR_RESTART)) &&
                                         !cmd_off && bias_ok;

    otfr_cmp u_cmp (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .temp_meas (temp_meas),
        .fault_thr (fault_thr_reg),
        .warn_thr  (warn_thr_reg),
        .fault_lvl (fault_lvl),
        .warn_lvl  (warn_lvl)
    );

    otfr_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .clr  (enter_delay),
        .tick (tick)
    );

    // register writes; unknown codes are ignored and flagged on read or write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reaction_reg  <= otfr_pkg::REACTION_RST;
            fault_thr_reg <= otfr_pkg::FAULT_THR_RST;
            warn_thr_reg  <= otfr_pkg::WARN_THR_RST;
        end else if (ce && cmd_wr) begin
            if (hit_reaction) begin
                reaction_reg <= cmd_wdata[otfr_pkg::REACT_W-1:0];
            end
            if (hit_fault_thr) begin
                fault_thr_reg <= cmd_wdata;
            end
            if (hit_warn_thr) begin
                warn_thr_reg <= cmd_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_rdata   <= otfr_pkg::RDATA_ZERO;
            cmd_unknown <= 1'b0;
        end else if (ce && (cmd_rd || cmd_wr)) begin
            cmd_rdata   <= cmd_rd ? rdata_sel : cmd_rdata;
            cmd_unknown <= !hit_any;
        end
    end

    // response state machine
    always_comb begin
        state_next   = state_reg;
        attempt_next = attempt_reg;
        delay_next   = delay_reg;
        unique case (state_reg)
            otfr_pkg::OTFR_RUN: begin
                // R2 ignore keeps running
                // R3 shut down then retries
                if (shut_req) begin
                    attempt_next = otfr_pkg::CNT_ZERO;
                    // R1 delay field loaded
                    delay_next   = delay_f;
                    // R4 no retry latches
                    if (retry_f == otfr_pkg::RETRY_NONE) begin
                        state_next = otfr_pkg::OTFR_LATCHED;
                    end else begin
                        state_next = otfr_pkg::OTFR_DELAY;
                    end
                end
            end
            otfr_pkg::OTFR_DELAY: begin
                // R6 spacing between attempts
                if (stop_cond) begin
                    state_next = otfr_pkg::OTFR_LATCHED;
                end else if (delay_reg == otfr_pkg::CNT_ZERO) begin
                    state_next = otfr_pkg::OTFR_RESTART;
                    if (!forever_f) begin
                        attempt_next = attempt_reg + otfr_pkg::CNT_ONE;
                    end
                end else if (tick) begin
                    delay_next = delay_reg - otfr_pkg::CNT_ONE;
                end
            end
            otfr_pkg::OTFR_RESTART: begin
                // R5 R7 judge the attempt
                if (!fault_lvl) begin
                    state_next = otfr_pkg::OTFR_RUN;
                end else if (stop_cond || !more_tries) begin
                    state_next = otfr_pkg::OTFR_LATCHED;
                end else begin
                    state_next = otfr_pkg::OTFR_DELAY;
                    delay_next = delay_f;
                end
            end
            otfr_pkg::OTFR_LATCHED: begin
                // R4 R5 off until cleared
                if (fault_clear && !fault_lvl) begin
                    state_next = otfr_pkg::OTFR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= otfr_pkg::OTFR_RUN;
            attempt_reg <= otfr_pkg::CNT_ZERO;
            delay_reg   <= otfr_pkg::CNT_ZERO;
            out_enable  <= 1'b0;
            latched_off <= 1'b0;
        end else if (ce) begin
            state_reg   <= state_next;
            attempt_reg <= attempt_next;
            delay_reg   <= delay_next;
            out_enable  <= out_next;
            latched_off <= (state_next == otfr_pkg::OTFR_LATCHED);
        end
    end

    // sticky flags: a new event in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ot_fault_flag <= 1'b0;
            ot_warn_flag  <= 1'b0;
        end else if (ce) begin
            // R10 fault flagged
            ot_fault_flag <= fault_lvl || (ot_fault_flag && !fault_clear);
            // R8 warning flagged
            ot_warn_flag  <= warn_lvl || (ot_warn_flag && !fault_clear);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // R2 ignore keeps output
    chk_ignore_keeps_on: assert property ( // R2
        ce && state_reg == otfr_pkg::OTFR_RUN && fault_lvl &&
        resp_f == otfr_pkg::RESP_IGNORE && !cmd_off && bias_ok |=> out_enable)
        else $error("output dropped although fault is ignored");

    // R3 disable on fault
    chk_disable_on_fault: assert property ( // R3
        ce && state_reg == otfr_pkg::OTFR_RUN && shut_req |=> !out_enable)
        else $error("output kept on after disabling fault");

    // R4 no retry latches
    chk_no_retry_latch: assert property ( // R4
        ce && state_reg == otfr_pkg::OTFR_RUN && shut_req &&
        retry_f == otfr_pkg::RETRY_NONE |=> latched_off && !out_enable)
        else $error("no-retry setting did not latch off");

    // R5 attempt bound
    chk_retry_exhaust: assert property ( // R5
        ce && state_reg == otfr_pkg::OTFR_RESTART && fault_lvl && !forever_f &&
        attempt_reg >= retry_f |=> state_reg == otfr_pkg::OTFR_LATCHED)
        else $error("retry went beyond programmed count");

    // R5 counter range
    chk_attempt_range: assert property ( // R5
        state_reg == otfr_pkg::OTFR_RESTART && !forever_f |->
        attempt_reg != otfr_pkg::CNT_ZERO && attempt_reg <= retry_f)
        else $error("attempt number outside programmed range");

    // R6 delay counts ticks
    chk_delay_tick: assert property ( // R6
        ce && state_reg == otfr_pkg::OTFR_DELAY && !stop_cond && tick &&
        delay_reg != otfr_pkg::CNT_ZERO |=> delay_reg == $past(delay_reg) - 3'h1)
        else $error("delay did not step on unit tick");

    // R1 no restart before delay
    chk_delay_hold: assert property ( // R1
        state_reg == otfr_pkg::OTFR_DELAY && delay_reg != otfr_pkg::CNT_ZERO |=>
        state_reg != otfr_pkg::OTFR_RESTART)
        else $error("restart before delay elapsed");

    // R7 continuous retry
    chk_forever_retry: assert property ( // R7
        ce && state_reg == otfr_pkg::OTFR_RESTART && fault_lvl && forever_f &&
        !stop_cond |=> state_reg == otfr_pkg::OTFR_DELAY)
        else $error("continuous retry stopped without cause");

    // R7 stop ends retry
    chk_stop_ends_retry: assert property ( // R7
        ce && state_reg == otfr_pkg::OTFR_DELAY && stop_cond |=> latched_off)
        else $error("retry continued after stop condition");

    // R4 latched keeps off
    chk_latched_no_out: assert property ( // R4
        latched_off |-> !out_enable)
        else $error("output on while latched off");

    // R5 off until cleared
    chk_latched_hold: assert property ( // R5
        ce && state_reg == otfr_pkg::OTFR_LATCHED && !fault_clear |=> latched_off)
        else $error("latched state left without clear");

    // R4 clear releases latch
    chk_clear_release: assert property ( // R4
        ce && state_reg == otfr_pkg::OTFR_LATCHED && fault_clear && !fault_lvl |=>
        state_reg == otfr_pkg::OTFR_RUN && !latched_off)
        else $error("clear did not release latched state");

    // R10 fault flag set
    chk_fault_flag_set: assert property ( // R10
        ce && fault_lvl |=> ot_fault_flag)
        else $error("fault flag missing while fault present");

    // R8 warning flag set
    chk_warn_flag_set: assert property ( // R8
        ce && warn_lvl |=> ot_warn_flag)
        else $error("warning flag missing while warning present");

    // R6 delay frozen without enable
    chk_freeze_state: assert property ( // R6
        !ce |=> $stable(state_reg) && $stable(delay_reg) && $stable(out_enable))
        else $error("state moved while clock enable low");

    cov_ignored_fault: cover property (
        state_reg == otfr_pkg::OTFR_RUN && fault_lvl && resp_f == otfr_pkg::RESP_IGNORE);
    cov_restart_ok: cover property (
        state_reg == otfr_pkg::OTFR_RESTART ##1 state_reg == otfr_pkg::OTFR_RUN);
    cov_exhausted: cover property (
        state_reg == otfr_pkg::OTFR_RESTART ##1 state_reg == otfr_pkg::OTFR_LATCHED);
    cov_cleared: cover property (
        state_reg == otfr_pkg::OTFR_LATCHED ##1 state_reg == otfr_pkg::OTFR_RUN);

endmodule // otfr_top

// >>> tb/otfr_host_model.sv
module otfr_host_model (
    input  wire logic        clk,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_unknown
);
    timeunit 1ns;
    timeprecision 1ns;

    logic thr_code;

    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one strobe cycle; released lines flip so a stale value never looks current
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                          output logic [15:0] rd, output logic unk);
        thr_code = (code == otfr_pkg::CMD_FAULT_THR) || (code == otfr_pkg::CMD_WARN_THR);
        @(posedge clk);
        cmd_wr    <= wr;
        cmd_rd    <= ~wr;
        cmd_code  <= code;
        cmd_wdata <= thr_code ? {5'h00, wd[10:0]} : wd;
        @(posedge clk);
        cmd_wr    <= 1'b0;
        cmd_rd    <= 1'b0;
        cmd_code  <= ~code;
        cmd_wdata <= ~wd;
        #1;
        rd  = cmd_rdata;
        unk = cmd_unknown;
    endtask
endmodule // otfr_host_model

// >>> tb/tb_over_temp_fault_response.sv
module tb_over_temp_fault_response;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TK = 4;

    logic        clk, rstn, ce, cmd_wr, cmd_rd, cmd_off, bias_ok, other_fault, fault_clear;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, temp_meas, cmd_rdata, rdv, seed;
    logic        cmd_unknown, out_enable, ot_fault_flag, ot_warn_flag, latched_off, unk;
    int          fail_count, n_tests;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    otfr_top #(.TICK_CYCLES(TK)) otfr_top_inst (
        .clk(clk), .rstn(rstn), .ce(ce), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .temp_meas(temp_meas),
        .cmd_off(cmd_off), .bias_ok(bias_ok), .other_fault(other_fault),
        .fault_clear(fault_clear), .cmd_rdata(cmd_rdata), .cmd_unknown(cmd_unknown),
        .out_enable(out_enable), .ot_fault_flag(ot_fault_flag),
        .ot_warn_flag(ot_warn_flag), .latched_off(latched_off));

    otfr_host_model otfr_host_model_inst (
        .clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_unknown(cmd_unknown));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_warn(input int t, input int th);
        return t > th;
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        otfr_host_model_inst.access(1'b1, c, d, rdv, unk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] c, input logic [15:0] e,
                          input logic eu);
        otfr_host_model_inst.access(1'b0, c, 16'h0000, rdv, unk);
        chk_word(nm, e, rdv);
        chk_bit({nm, " unknown"}, eu, unk);
    endtask

    // sel 0 watches out_enable, sel 1 latched_off
    task automatic wait_cond(input int sel, input logic v, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge clk);
            #1;
            if ((sel ? latched_off : out_enable) === v) break;
        end
        if (i == bound) begin
            fail_count++;
            $display("Error wait %0d for %b timed out", sel, v);
            complete_run();
        end
    endtask

    task automatic recover;
        @(posedge clk);
        temp_meas   <= 16'h0014;
        cmd_off     <= 1'b0;
        bias_ok     <= 1'b1;
        other_fault <= 1'b0;
        repeat (3) @(posedge clk);
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
        wait_cond(0, 1'b1, 10);
    endtask

    // counts restarts as rising edges of the output until it latches off
    task automatic fault_run(input logic [7:0] r, input logic [15:0] t, input int n,
                             output int rises, output int gap, output logic fell);
        int   i;
        int   last;
        logic prev;
        wr(otfr_pkg::CMD_REACTION, {8'h00, r});
        @(posedge clk);
        temp_meas <= t;
        rises = 0;
        gap   = 0;
        fell  = 1'b0;
        last  = 0;
        prev  = 1'b1;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (out_enable === 1'b0) fell = 1'b1;
            if (out_enable === 1'b1 && prev === 1'b0) begin
                rises++;
                gap  = i - last;
                last = i;
            end
            prev = out_enable;
            if (latched_off === 1'b1) break;
        end
    endtask

    initial begin
        int          k, d, rises, gap, tv, thr;
        logic        fell;
        logic [7:0]  r;
        rstn = 1'b0; ce = 1'b1; cmd_off = 1'b0; bias_ok = 1'b1; other_fault = 1'b0;
        fault_clear = 1'b0; temp_meas = 16'h0014; seed = 16'h3B81;
        fail_count = 0; n_tests = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk_bit("out_enable start", 1'b1, out_enable);
        rd_chk("reaction rst", otfr_pkg::CMD_REACTION, 16'h0080, 1'b0);
        rd_chk("fault thr rst", otfr_pkg::CMD_FAULT_THR, 16'h007D, 1'b0);
        rd_chk("warn thr rst", otfr_pkg::CMD_WARN_THR, 16'h0073, 1'b0);
        // clock enable low: neither the write nor the hot reading may be taken
        @(posedge clk);
        ce        <= 1'b0;
        temp_meas <= 16'h00C8;
        wr(otfr_pkg::CMD_WARN_THR, 16'h0010);
        chk_bit("frozen unknown", 1'b0, unk);
        chk_bit("frozen flag", 1'b0, ot_fault_flag);
        chk_bit("frozen output", 1'b1, out_enable);
        @(posedge clk);
        ce        <= 1'b1;
        temp_meas <= 16'h0014;
        rd_chk("frozen write", otfr_pkg::CMD_WARN_THR, 16'h0073, 1'b0);
        wr(8'h52, 16'h1234);
        chk_bit("unknown write", 1'b1, unk);
        rd_chk("unknown read", 8'h52, 16'h0000, 1'b1);
        wr(otfr_pkg::CMD_REACTION, 16'hAB8A);
        rd_chk("reaction byte", otfr_pkg::CMD_REACTION, 16'h008A, 1'b0);
        wr(otfr_pkg::CMD_FAULT_THR, 16'h0064);
        rd_chk("fault thr", otfr_pkg::CMD_FAULT_THR, 16'h0064, 1'b0);
        for (k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            thr  = 20 + int'(seed[5:0]);
            tv   = thr + int'(seed[7:6]) % 3 - 1;
            wr(otfr_pkg::CMD_WARN_THR, 16'(thr));
            @(posedge clk);
            temp_meas <= 16'(tv);
            repeat (4) @(posedge clk);
            #1;
            chk_bit("warn flag", exp_warn(tv, thr), ot_warn_flag);
            chk_bit("fault flag quiet", 1'b0, ot_fault_flag);
            recover();
        end
        fault_run(8'h80, 16'h0064, 20, rises, gap, fell);
        chk_bit("equal no trip", 1'b0, fell);
        recover();
        fault_run(8'h80, 16'h0065, 20, rises, gap, fell);
        chk_bit("no retry latched", 1'b1, latched_off);
        chk_word("no retry count", 16'h0000, 16'(rises));
        chk_bit("fault flag", 1'b1, ot_fault_flag);
        recover();
        chk_bit("flag cleared", 1'b0, ot_fault_flag);
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            r    = {k == 0 ? 2'h0 : (k == 1 ? 2'h1 : 2'h3), seed[5:0]};
            fault_run(r, 16'h00C8, 30, rises, gap, fell);
            chk_bit("ignore output", 1'b0, fell);
            chk_bit("ignore flag", 1'b1, ot_fault_flag);
            recover();
        end
        for (k = 1; k < 7; k++) begin
            seed = lfsr(seed);
            d    = 1 + int'(seed[1:0]) % 3;
            fault_run({2'h2, k[2:0], d[2:0]}, 16'h00C8, (k + 1) * (d * TK + 6) + 10,
                      rises, gap, fell);
            chk_bit("retries latched", 1'b1, latched_off);
            chk_word("retries", 16'(k), 16'(rises));
            chk_bit("latched output", 1'b0, out_enable);
            if (k >= 2) chk_bit("retry gap", gap >= d * TK && gap <= d * TK + 4, 1'b1);
            recover();
        end
        for (k = 0; k < 3; k++) begin
            fault_run(8'hB9, 16'h00C8, 60, rises, gap, fell);
            chk_bit("continuous running", 1'b0, latched_off);
            chk_bit("continuous count", rises >= 6, 1'b1);
            @(posedge clk);
            if (k == 0) cmd_off <= 1'b1;
            if (k == 1) bias_ok <= 1'b0;
            if (k == 2) other_fault <= 1'b1;
            wait_cond(1, 1'b1, 20);
            chk_bit("continuous stop", 1'b0, out_enable);
            recover();
        end
        // mid-run reset brings back the register defaults
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk_word("rdata reset", 16'h0000, cmd_rdata);
        chk_bit("reset output", 1'b1, out_enable);
        rd_chk("reaction reset", otfr_pkg::CMD_REACTION, 16'h0080, 1'b0);
        complete_run();
    end
endmodule // tb_over_temp_fault_response
